// file: ccsr_pkg.sv
`default_nettype none
// =====================================================================
// channel current setting register bank: shared constants and types
package ccsr_pkg;

  // =====================================================================
  // register indices (byte address on the bus is four times the index)
  localparam logic [7:0] CCSR_IDX_CH_A0 = 8'h50;
  localparam logic [7:0] CCSR_IDX_CH_A1 = 8'h51;
  localparam logic [7:0] CCSR_IDX_CH_B0 = 8'h52;
  localparam logic [7:0] CCSR_IDX_CH_B1 = 8'h53;
  localparam logic [7:0] CCSR_IDX_CH_C0 = 8'h54;
  localparam logic [7:0] CCSR_IDX_CH_C1 = 8'h55;
  localparam logic [7:0] CCSR_IDX_CH_D0 = 8'h56;
  localparam logic [7:0] CCSR_IDX_CH_D1 = 8'h57;
  localparam logic [7:0] CCSR_IDX_CH_E0 = 8'h58;
  localparam logic [7:0] CCSR_IDX_CH_E1 = 8'h59;
  localparam logic [7:0] CCSR_IDX_CH_F0 = 8'h5A;

  // =====================================================================
  // layout of one current-code register
  localparam int         CCSR_REG_W     = 8;
  localparam int         CCSR_CODE_W    = 6;
  localparam int         CCSR_CODE_LSB  = 0;
  localparam logic [1:0] CCSR_RSVD_VAL  = 2'h0;
  localparam int         CCSR_CH_COUNT  = 11;
  localparam int         CCSR_CH_MAX    = 16;

  // =====================================================================
  // bus geometry and responses
  localparam int         CCSR_ADDR_W    = 12;
  localparam int         CCSR_DATA_W    = 32;
  localparam int         CCSR_STRB_W    = 4;
  localparam logic [1:0] CCSR_RESP_OKAY = 2'h0;
  localparam logic [1:0] CCSR_RESP_SLV  = 2'h2;

  typedef logic [CCSR_CODE_W-1:0] ccsr_code_t;

  // held write request: address, data and lane strobes travel together
  typedef struct packed {
    logic [CCSR_ADDR_W-1:0] addr;
    logic [CCSR_DATA_W-1:0] data;
    logic [CCSR_STRB_W-1:0] strb;
  } ccsr_wreq_s;

endpackage : ccsr_pkg
`default_nettype wire

// file: ccsr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module ccsr_regs #(
  parameter int NUM_CH = ccsr_pkg::CCSR_CH_COUNT
) (
  // clock and reset
  input  wire  logic                                        aclk,
  input  wire  logic                                        aresetn,
  // stored nonvolatile codes, channel 0 (a0) in the low slot
  input  wire  logic [NUM_CH-1:0][ccsr_pkg::CCSR_CODE_W-1:0] nvm_code,
  // codes driving the current sources, channel 0 (a0) in the low slot
  output var   logic [NUM_CH-1:0][ccsr_pkg::CCSR_CODE_W-1:0] current_code,
  // write address channel
  input  wire  logic                                        s_axi_awvalid,
  output var   logic                                        s_axi_awready,
  input  wire  logic [ccsr_pkg::CCSR_ADDR_W-1:0]            s_axi_awaddr,
  input  wire  logic [2:0]                                  s_axi_awprot,
  // write data channel
  input  wire  logic                                        s_axi_wvalid,
  output var   logic                                        s_axi_wready,
  input  wire  logic [ccsr_pkg::CCSR_DATA_W-1:0]            s_axi_wdata,
  input  wire  logic [ccsr_pkg::CCSR_STRB_W-1:0]            s_axi_wstrb,
  // write response channel
  output var   logic                                        s_axi_bvalid,
  input  wire  logic                                        s_axi_bready,
  output var   logic [1:0]                                  s_axi_bresp,
  // read address channel
  input  wire  logic                                        s_axi_arvalid,
  output var   logic                                        s_axi_arready,
  input  wire  logic [ccsr_pkg::CCSR_ADDR_W-1:0]            s_axi_araddr,
  input  wire  logic [2:0]                                  s_axi_arprot,
  // read data channel
  output var   logic                                        s_axi_rvalid,
  input  wire  logic                                        s_axi_rready,
  output var   logic [ccsr_pkg::CCSR_DATA_W-1:0]            s_axi_rdata,
  output var   logic [1:0]                                  s_axi_rresp
);
  import ccsr_pkg::*;

  // =====================================================================
  // elaboration checks
  if (NUM_CH < 1 || NUM_CH > CCSR_CH_MAX) begin : g_bad_count
    $error("ccsr_regs: NUM_CH must lie between 1 and 16");
  end

  localparam int IDX_W = CCSR_ADDR_W - 2;

  // =====================================================================
  // address decode: hit flag in bit 4, channel slot in bits 3..0
  function automatic logic [4:0] decode_slot(input logic [CCSR_ADDR_W-1:0] addr);
    logic [IDX_W-1:0] idx;
    logic [IDX_W-1:0] off;
    logic             hit;
    idx = addr[CCSR_ADDR_W-1:2];
    off = idx - IDX_W'(CCSR_IDX_CH_A0);
    hit = (addr[1:0] == 2'h0) && (idx >= IDX_W'(CCSR_IDX_CH_A0))
          && (off < IDX_W'(NUM_CH));
    decode_slot = {hit, off[3:0]};
  endfunction

  // =====================================================================
  // state
  logic [NUM_CH-1:0][CCSR_CODE_W-1:0] code_q;
  ccsr_wreq_s                         wreq_q;
  logic                               aw_held_q;
  logic                               w_held_q;
  logic                               awready_q;
  logic                               wready_q;
  logic                               bvalid_q;
  logic [1:0]                         bresp_q;
  logic                               arready_q;
  logic                               rvalid_q;
  logic [CCSR_DATA_W-1:0]             rdata_q;
  logic [1:0]                         rresp_q;

  // =====================================================================
  // handshakes and decode
  wire logic       aw_take   = s_axi_awvalid && awready_q;
  wire logic       w_take    = s_axi_wvalid && wready_q;
  wire logic       b_done    = bvalid_q && s_axi_bready;
  wire logic       ar_take   = s_axi_arvalid && arready_q;
  wire logic       r_done    = rvalid_q && s_axi_rready;
  wire logic       commit    = aw_held_q && w_held_q && !bvalid_q;
  wire logic [4:0] wr_dec    = decode_slot(wreq_q.addr);
  wire logic [4:0] rd_dec    = decode_slot(s_axi_araddr);
  wire logic       wr_hit    = wr_dec[4];
  wire logic [3:0] wr_slot   = wr_dec[3:0];
  wire logic       rd_hit    = rd_dec[4];
  wire logic [3:0] rd_slot   = rd_dec[3:0];
  wire logic       wr_lane0  = wreq_q.strb[0];

  // read word: reserved bits and upper lanes are zero
  wire logic [CCSR_REG_W-1:0] rd_byte =
    rd_hit ? {CCSR_RSVD_VAL, code_q[rd_slot]} : CCSR_REG_W'(0);
  wire logic [CCSR_DATA_W-1:0] rd_word = {(CCSR_DATA_W-CCSR_REG_W)'(0), rd_byte};

  // =====================================================================
  // current codes: nonvolatile load in reset, bus writes afterwards
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      code_q <= nvm_code;
    end else if (commit && wr_hit && wr_lane0) begin
      code_q[wr_slot] <= wreq_q.data[CCSR_CODE_LSB +: CCSR_CODE_W];
    end
  end

  // =====================================================================
  // write address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wreq_q    <= '0;
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
    end else begin
      if (aw_take) begin
        wreq_q.addr <= s_axi_awaddr;
        aw_held_q   <= 1'b1;
      end
      if (w_take) begin
        wreq_q.data <= s_axi_wdata;
        wreq_q.strb <= s_axi_wstrb;
        w_held_q    <= 1'b1;
      end
      if (commit) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
      end
    end
  end

  // =====================================================================
  // write readies and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= CCSR_RESP_OKAY;
    end else begin
      if (aw_take) begin
        awready_q <= 1'b0;
      end else if (!aw_held_q && !bvalid_q) begin
        awready_q <= 1'b1;
      end
      if (w_take) begin
        wready_q <= 1'b0;
      end else if (!w_held_q && !bvalid_q) begin
        wready_q <= 1'b1;
      end
      if (commit) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_hit ? CCSR_RESP_OKAY : CCSR_RESP_SLV;
      end else if (b_done) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // =====================================================================
  // read path: one beat answered the cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= CCSR_RESP_OKAY;
    end else begin
      if (ar_take) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rdata_q   <= rd_word;
        rresp_q   <= rd_hit ? CCSR_RESP_OKAY : CCSR_RESP_SLV;
      end else if (r_done) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end else if (!rvalid_q) begin
        arready_q <= 1'b1;
      end
    end
  end

  // =====================================================================
  // outputs straight from flip-flops
  assign current_code  = code_q;
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

endmodule // ccsr_regs
`default_nettype wire

// file: ccsr_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// checker on the code bank ports
module ccsr_regs_monitor
  import ccsr_pkg::*;
#(
  parameter int NUM_CH = 11
) (
  // clock, reset and codes
  input wire logic                              aclk,
  input wire logic                              aresetn,
  input wire logic [NUM_CH-1:0][CCSR_CODE_W-1:0] nvm_code,
  input wire logic [NUM_CH-1:0][CCSR_CODE_W-1:0] current_code,
  // bus answers
  input wire logic                              s_axi_arvalid,
  input wire logic                              s_axi_arready,
  input wire logic                              s_axi_rvalid,
  input wire logic [31:0]                       s_axi_rdata,
  input wire logic                              s_axi_bvalid,
  input wire logic [1:0]                        s_axi_bresp
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // codes come up from the stored values
  a_reset_load: assert property ($rose(aresetn) |-> current_code == $past(nvm_code))
    else $error("code not loaded at reset");
  // a taken read answers on the next edge
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  // reserved and upper bits read zero
  a_rsvd_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:6] == 26'h0)
    else $error("reserved bits not zero");
  // refused writes leave every code alone
  a_bad_drop: assert property ($rose(s_axi_bvalid) && s_axi_bresp == CCSR_RESP_SLV
    |-> $stable(current_code))
    else $error("unmapped write changed a code");
  // codes move only on the edge that raises the write response
  a_code_held: assert property ($past(aresetn) && !$rose(s_axi_bvalid)
    |-> $stable(current_code))
    else $error("code changed without a write");
endmodule // ccsr_regs_monitor
`default_nettype wire

// file: tb.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// self-checking bench for the current code bank
module tb;
  import ccsr_pkg::*;
  localparam int N = CCSR_CH_COUNT;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [N-1:0][CCSR_CODE_W-1:0] nvm_code, current_code;
  logic [5:0]  ref_c [N];
  int          n_fail, total_checks, seed;
  ccsr_regs #(.NUM_CH(N)) dut (.aclk, .aresetn, .nvm_code, .current_code, .s_axi_awvalid,
    .s_axi_awready, .s_axi_awaddr, .s_axi_awprot, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_arprot, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
  // clock and watchdog
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  initial begin
    #200000;
    n_fail++;
    complete_run();
  end
  function automatic logic [11:0] adr(int k);
    return {2'h0, CCSR_IDX_CH_A0 + 8'(k), 2'h0};
  endfunction
  function automatic logic [31:0] exp_word(logic [5:0] c);
    return {26'h0, c};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    @(posedge aclk);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    s_axi_araddr <= a;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  // reset with fresh random stored codes
  task automatic do_reset();
    logic [31:0] v;
    @(posedge aclk);
    aresetn <= 1'b0;
    for (int k = 0; k < N; k++) begin
      v = $random(seed);
      nvm_code[k] <= v[5:0];
      ref_c[k] = v[5:0];
    end
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask
  task automatic check_all();
    logic [31:0] d;
    logic [1:0]  r;
    for (int k = 0; k < N; k++) begin
      rd(adr(k), d, r);
      chk(d, exp_word(ref_c[k]));
      chk(32'(r), 32'(CCSR_RESP_OKAY));
      chk(32'(current_code[k]), 32'(ref_c[k]));
    end
  endtask
  // main sequence
  initial begin
    logic [31:0] v, d;
    logic [1:0]  r;
    int          k;
    logic [11:0] bad [3];
    bad = '{12'h16C, 12'h13C, 12'h141};
    seed = 69442;
    {n_fail, total_checks} = '0;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, nvm_code} = '0;
    {s_axi_awprot, s_axi_arprot} = '0;
    do_reset();
    check_all();
    // random codes with reserved bits set and random upper bits, read straight back
    repeat (30) begin
      k = $unsigned($random(seed)) % N;
      v = $random(seed) | 32'hC0;
      wr(adr(k), v, 4'h1 | v[11:8], r);
      chk(32'(r), 32'(CCSR_RESP_OKAY));
      ref_c[k] = v[5:0];
      rd(adr(k), d, r);
      chk(d, exp_word(ref_c[k]));
    end
    // lane 0 off leaves the code alone
    wr(adr(0), 32'h15, 4'hE, r);
    chk(32'(r), 32'(CCSR_RESP_OKAY));
    chk(32'(current_code[0]), 32'(ref_c[0]));
    // unmapped places answer with an error and change nothing
    for (int i = 0; i < 3; i++) begin
      wr(bad[i], 32'h3F, 4'hF, r);
      chk(32'(r), 32'(CCSR_RESP_SLV));
      rd(bad[i], d, r);
      chk(d, 32'h0);
      chk(32'(r), 32'(CCSR_RESP_SLV));
    end
    check_all();
    do_reset();
    check_all();
    complete_run();
  end
endmodule // tb
bind ccsr_regs ccsr_regs_monitor #(.NUM_CH(NUM_CH)) u_mon (.aclk, .aresetn, .nvm_code,
  .current_code, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .s_axi_bvalid,
  .s_axi_bresp);
`default_nettype wire
